// ---- include/spsc_pkg.sv ----
package spsc_pkg;
	localparam int BIDIR_B_W   = 4;
	localparam int BIDIR_C_W   = 2;
	localparam int BIDIR_D_W   = 4;
	localparam int ANALOG_W    = 4;
	localparam int OUT_A_W     = 4;
	localparam int OUT_B_W     = 4;
	localparam int SEG_W       = 15;
	localparam logic SEG_OFF   = 1'b0;
	localparam logic CRYSTAL_OUT_STOP = 1'b1;
	localparam logic PD_ON     = 1'b1;
	typedef enum logic [1:0] {
		SPSC_RUN,
		SPSC_HALT,
		SPSC_STOP
	} spsc_state_e;
endpackage

// ---- rtl/spsc_standby_pins.sv ----
`timescale 1ns/1ps
// Operation
// - Clock stop turns all bidirectional port pins into plain inputs.
// - Clock stop leaves the analog input port configuration untouched.
// - Output ports stay outputs and hold their level during clock stop.
// - Clock stop forces segment pins to segment function, driven low.
// - Clock stop disables synthesizer and floats its drive and error pins.
// - Chip-enable low disables synthesizer and floats its pins always.
// - Clock stop pulls crystal input down and drives crystal output high.
// - Analog port pull-down is software selectable; off means floating.
// - Segment pins usable as outputs keep their values through halt.
// - Stop request honoured only with chip-enable low, else no effect.
// - Halt stops only instruction execution; pins keep working.
module spsc_standby_pins #(
	parameter int BB_W  = spsc_pkg::BIDIR_B_W,
	parameter int BC_W  = spsc_pkg::BIDIR_C_W,
	parameter int BD_W  = spsc_pkg::BIDIR_D_W,
	parameter int AN_W  = spsc_pkg::ANALOG_W,
	parameter int OA_W  = spsc_pkg::OUT_A_W,
	parameter int OB_W  = spsc_pkg::OUT_B_W,
	parameter int SG_W  = spsc_pkg::SEG_W
) (
	// Clock and reset.
	input  wire logic            clk,
	input  wire logic            reset_n,
	// Chip-enable pin and CPU standby requests.
	input  wire logic            chip_enable,
	input  wire logic            halt_req,
	input  wire logic            stop_req,
	input  wire logic            wake_req,
	// Peripheral port settings in normal operation.
	input  wire logic [BB_W-1:0] bidir_port_b_out,
	input  wire logic [BB_W-1:0] bidir_port_b_oe,
	input  wire logic [BC_W-1:0] bidir_port_c_out,
	input  wire logic [BC_W-1:0] bidir_port_c_oe,
	input  wire logic [BD_W-1:0] bidir_port_d_out,
	input  wire logic [BD_W-1:0] bidir_port_d_oe,
	input  wire logic            analog_pd_sel,
	input  wire logic [OA_W-1:0] output_port_a_val,
	input  wire logic [OB_W-1:0] output_port_b_val,
	input  wire logic            output_port_c_serial_out_val,
	input  wire logic [SG_W-1:0] seg_gpo_sel,
	input  wire logic [SG_W-1:0] seg_gpo_val,
	input  wire logic [SG_W-1:0] seg_drive_val,
	input  wire logic            synth_sw_enable,
	input  wire logic            synth_drive_low_val,
	input  wire logic            synth_drive_high_val,
	input  wire logic            phase_error_val,
	// Port pins.
	output logic      [BB_W-1:0] bidir_port_b,
	output logic      [BB_W-1:0] bidir_port_b_en,
	output logic      [BC_W-1:0] bidir_port_c,
	output logic      [BC_W-1:0] bidir_port_c_en,
	output logic      [BD_W-1:0] bidir_port_d,
	output logic      [BD_W-1:0] bidir_port_d_en,
	output logic                 analog_input_port_pd,
	output logic      [OA_W-1:0] output_port_a,
	output logic      [OB_W-1:0] output_port_b,
	output logic                 output_port_c_serial_out,
	output logic      [SG_W-1:0] segment_pins,
	output logic                 synth_drive_low_pin,
	output logic                 synth_drive_low_pin_en,
	output logic                 synth_drive_high_pin,
	output logic                 synth_drive_high_pin_en,
	output logic                 phase_error_out,
	output logic                 phase_error_out_en,
	output logic                 crystal_in_pd,
	output logic                 crystal_out,
	// Status.
	output logic                 in_halt,
	output logic                 in_stop
);

	spsc_pkg::spsc_state_e state;
	spsc_pkg::spsc_state_e next_state;
	logic ce_meta;
	logic ce_sync;
	logic stopping;
	logic synth_on;

	// Chip-enable is a raw pin, so two flops settle it before any use.
	always_ff @(posedge clk) begin
		ce_meta <= chip_enable;
		ce_sync <= ce_meta;
	end

	assign stopping = (state != spsc_pkg::SPSC_STOP) && stop_req
		&& !ce_sync;

	always_comb begin
		next_state = state;
		case (state)
			spsc_pkg::SPSC_RUN: begin
				if (stopping) begin
					next_state = spsc_pkg::SPSC_STOP;
				end else if (halt_req) begin
					next_state = spsc_pkg::SPSC_HALT;
				end
			end
			spsc_pkg::SPSC_HALT: begin
				if (stopping) begin
					next_state = spsc_pkg::SPSC_STOP;
				end else if (wake_req) begin
					next_state = spsc_pkg::SPSC_RUN;
				end
			end
			spsc_pkg::SPSC_STOP: begin
				if (wake_req) begin
					next_state = spsc_pkg::SPSC_RUN;
				end
			end
			default: next_state = spsc_pkg::SPSC_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= spsc_pkg::SPSC_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Output latches capture the driven level on every non-stop cycle.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			output_port_a            <= '0;
			output_port_b            <= '0;
			output_port_c_serial_out <= 1'b0;
		end else if (next_state != spsc_pkg::SPSC_STOP) begin
			output_port_a            <= output_port_a_val;
			output_port_b            <= output_port_b_val;
			output_port_c_serial_out <= output_port_c_serial_out_val;
		end
		// Clock stop freezes output ports at their last level.
		// They follow again on the wake edge, together with the other pins.
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bidir_port_b    <= '0;
			bidir_port_b_en <= '0;
			bidir_port_c    <= '0;
			bidir_port_c_en <= '0;
			bidir_port_d    <= '0;
			bidir_port_d_en <= '0;
		end else if (next_state == spsc_pkg::SPSC_STOP) begin
			bidir_port_b_en <= '0;
			bidir_port_c_en <= '0;
			bidir_port_d_en <= '0;
		end else begin
			bidir_port_b    <= bidir_port_b_out;
			bidir_port_b_en <= bidir_port_b_oe;
			bidir_port_c    <= bidir_port_c_out;
			bidir_port_c_en <= bidir_port_c_oe;
			bidir_port_d    <= bidir_port_d_out;
			bidir_port_d_en <= bidir_port_d_oe;
		end
	end

	// Pull-down setting is kept across clock stop.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			analog_input_port_pd <= 1'b0;
		end else if (next_state != spsc_pkg::SPSC_STOP) begin
			analog_input_port_pd <= analog_pd_sel;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			segment_pins <= '0;
		end else if (next_state == spsc_pkg::SPSC_STOP) begin
			segment_pins <= {SG_W{spsc_pkg::SEG_OFF}};
		end else begin
			for (int i = 0; i < SG_W; i++) begin
				segment_pins[i] <= seg_gpo_sel[i] ? seg_gpo_val[i]
					: seg_drive_val[i];
			end
		end
	end

	assign synth_on = ce_sync && synth_sw_enable
		&& next_state != spsc_pkg::SPSC_STOP;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			synth_drive_low_pin     <= 1'b0;
			synth_drive_low_pin_en  <= 1'b0;
			synth_drive_high_pin    <= 1'b0;
			synth_drive_high_pin_en <= 1'b0;
			phase_error_out         <= 1'b0;
			phase_error_out_en      <= 1'b0;
		end else begin
			synth_drive_low_pin     <= synth_drive_low_val;
			synth_drive_low_pin_en  <= synth_on;
			synth_drive_high_pin    <= synth_drive_high_val;
			synth_drive_high_pin_en <= synth_on;
			phase_error_out         <= phase_error_val;
			phase_error_out_en      <= synth_on;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			crystal_in_pd <= 1'b0;
			crystal_out   <= 1'b0;
			in_halt       <= 1'b0;
			in_stop       <= 1'b0;
		end else begin
			crystal_in_pd <= (next_state == spsc_pkg::SPSC_STOP)
				? spsc_pkg::PD_ON : 1'b0;
			crystal_out   <= (next_state == spsc_pkg::SPSC_STOP)
				? spsc_pkg::CRYSTAL_OUT_STOP : 1'b0;
			in_halt       <= next_state == spsc_pkg::SPSC_HALT;
			in_stop       <= next_state == spsc_pkg::SPSC_STOP;
		end
	end

endmodule // spsc_standby_pins

// ---- test/spsc_board.sv ----
`timescale 1ns/1ps
// Board wiring on a bidirectional port: a released pin reads as the
// board's pull-down level, never the last value the device drove.
module spsc_board #(
	parameter int W = 4
) (
	// Device side of the pins.
	input  wire logic [W-1:0] pin,
	input  wire logic [W-1:0] en,
	// Level seen on the board.
	output logic      [W-1:0] lvl
);
	assign lvl = pin & en;
endmodule // spsc_board

// ---- test/spsc_standby_pins_assertions.sv ----
`timescale 1ns/1ps
module spsc_chk (
	// Clock, reset and requests.
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        chip_enable,
	input  wire logic        stop_req,
	input  wire logic        halt_req,
	// Pins and status.
	input  wire logic [3:0]  bidir_port_b_en,
	input  wire logic [3:0]  bidir_port_d_en,
	input  wire logic [3:0]  output_port_a,
	input  wire logic [3:0]  output_port_b,
	input  wire logic [1:0]  bidir_port_c_en,
	input  wire logic [14:0] segment_pins,
	input  wire logic        analog_input_port_pd,
	input  wire logic        output_port_c_serial_out,
	input  wire logic        synth_drive_low_pin_en,
	input  wire logic        synth_drive_high_pin_en,
	input  wire logic        phase_error_out_en,
	input  wire logic        crystal_in_pd,
	input  wire logic        crystal_out,
	input  wire logic        in_halt,
	input  wire logic        in_stop
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_stop_bidir_in: assert property (
		in_stop |-> !(|{bidir_port_b_en, bidir_port_c_en, bidir_port_d_en}))
		else $error("bidir pin driven in stop");
	a_stop_pd_kept: assert property (
		in_stop |-> $stable(analog_input_port_pd))
		else $error("analog pull-down changed in stop");
	a_stop_out_held: assert property (
		in_stop |-> $stable({output_port_a, output_port_b,
		output_port_c_serial_out})) else $error("output port moved in stop");
	a_stop_seg_low: assert property (
		in_stop |-> segment_pins == 15'h0000)
		else $error("segment pins not low in stop");
	a_stop_synth_off: assert property (
		in_stop |-> !(synth_drive_low_pin_en || synth_drive_high_pin_en ||
		phase_error_out_en)) else $error("synth pin driven in stop");
	a_ce_low_synth: assert property (
		!chip_enable [*4] |-> !(synth_drive_low_pin_en ||
		synth_drive_high_pin_en)) else $error("synth on with enable low");
	a_stop_crystal: assert property (
		in_stop |-> crystal_in_pd && crystal_out == spsc_pkg::CRYSTAL_OUT_STOP)
		else $error("crystal pins wrong in stop");
	a_ce_high_nop: assert property (
		chip_enable [*4] ##0 !in_stop |=> !in_stop)
		else $error("stop taken with enable high");
	c_stop: cover property ($rose(in_stop));
	c_halt: cover property ($rose(in_halt));
	c_nop: cover property (chip_enable && stop_req);
endmodule // spsc_chk
bind spsc_standby_pins spsc_chk u_spsc_chk (.*);

// ---- test/spsc_standby_pins_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	failures++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module spsc_standby_pins_tb;
	logic        clk, reset_n, chip_enable, halt_req, stop_req, wake_req;
	logic [3:0]  bidir_port_b_out, bidir_port_b_oe, bidir_port_d_out;
	logic [3:0]  bidir_port_d_oe, output_port_a_val, output_port_b_val;
	logic [1:0]  bidir_port_c_out, bidir_port_c_oe, bidir_port_c;
	logic [1:0]  bidir_port_c_en;
	logic        analog_pd_sel, output_port_c_serial_out_val, synth_sw_enable;
	logic        synth_drive_low_val, synth_drive_high_val, phase_error_val;
	logic [14:0] seg_gpo_sel, seg_gpo_val, seg_drive_val, segment_pins;
	logic [3:0]  bidir_port_b, bidir_port_b_en, bidir_port_d, b_lvl;
	logic [3:0]  bidir_port_d_en, output_port_a, output_port_b;
	logic        analog_input_port_pd, output_port_c_serial_out, crystal_out;
	logic        synth_drive_low_pin, synth_drive_low_pin_en, in_halt, in_stop;
	logic        synth_drive_high_pin, synth_drive_high_pin_en, crystal_in_pd;
	logic        phase_error_out, phase_error_out_en;
	int          failures, compares;
	logic [2:0]  synth_en, synth_val;
	logic [4:0]  port_bc;
	assign synth_en = {synth_drive_low_pin_en, synth_drive_high_pin_en,
		phase_error_out_en};
	assign synth_val = {synth_drive_low_pin, synth_drive_high_pin,
		phase_error_out};
	assign port_bc = {output_port_b, output_port_c_serial_out};
	spsc_standby_pins u_spsc_standby_pins (.*);
	spsc_board u_spsc_board (.pin(bidir_port_b), .en(bidir_port_b_en),
		.lvl(b_lvl));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Request bits in the order halt, stop, wake; one cycle wide.
	task pulse_req(input logic [2:0] req);
		@(posedge clk);
		{halt_req, stop_req, wake_req} <= req;
		@(posedge clk);
		{halt_req, stop_req, wake_req} <= 3'h0;
		@(negedge clk);
	endtask
	task t_stop;
		@(posedge clk);
		{bidir_port_b_oe, bidir_port_b_out} <= 8'hFA;
		{bidir_port_d_oe, bidir_port_d_out, bidir_port_c_oe,
			bidir_port_c_out} <= 12'hC36;
		{output_port_a_val, analog_pd_sel, synth_sw_enable} <= 6'h17;
		{output_port_b_val, output_port_c_serial_out_val} <= 5'h13;
		{synth_drive_low_val, synth_drive_high_val, phase_error_val} <= 3'h5;
		chip_enable <= 1'b1;
		seg_drive_val <= 15'h7FFF;
		repeat (5) @(negedge clk);
		`CHK("synth en", 1'b1, synth_drive_high_pin_en)
		`CHK("synth all en", 3'h7, synth_en)
		`CHK("synth val", 3'h5, synth_val)
		`CHK("port c", 4'h6, {bidir_port_c_en, bidir_port_c})
		`CHK("port d", 8'hC3, {bidir_port_d_en, bidir_port_d})
		`CHK("port b", 5'h13, port_bc)
		@(posedge clk);
		chip_enable <= 1'b0;
		repeat (5) @(negedge clk);
		`CHK("synth en", 1'b0, synth_drive_high_pin_en)
		pulse_req(3'h2);
		`CHK("in_stop", 1'b1, in_stop)
		`CHK("board b", 4'h0, b_lvl)
		`CHK("port c", 4'h2, {bidir_port_c_en, bidir_port_c})
		`CHK("port d", 8'h03, {bidir_port_d_en, bidir_port_d})
		`CHK("pd", 1'b1, analog_input_port_pd)
		`CHK("segs", 15'h0000, segment_pins)
		`CHK("eo en", 1'b0, phase_error_out_en)
		`CHK("synth all en", 3'h0, synth_en)
		`CHK("xtal", 2'b11, {crystal_in_pd, crystal_out})
		@(posedge clk);
		output_port_a_val <= 4'h3;
		{output_port_b_val, output_port_c_serial_out_val} <= 5'h00;
		analog_pd_sel <= 1'b0;
		@(negedge clk);
		`CHK("port a", 4'h5, output_port_a)
		`CHK("port b", 5'h13, port_bc)
		`CHK("pd", 1'b1, analog_input_port_pd)
		pulse_req(3'h1);
		`CHK("port a", 4'h3, output_port_a)
		`CHK("port b", 5'h00, port_bc)
		`CHK("board b", 4'hA, b_lvl)
		`CHK("pd", 1'b0, analog_input_port_pd)
		`CHK("xtal", 2'b00, {crystal_in_pd, crystal_out})
	endtask
	task t_nop;
		@(posedge clk);
		chip_enable <= 1'b1;
		repeat (5) @(negedge clk);
		pulse_req(3'h2);
		`CHK("in_stop", 1'b0, in_stop)
		`CHK("board b", 4'hA, b_lvl)
	endtask
	task t_halt;
		@(posedge clk);
		{seg_gpo_sel, seg_gpo_val} <= 30'h3FFF_9234;
		pulse_req(3'h4);
		`CHK("in_halt", 1'b1, in_halt)
		`CHK("segs", 15'h1234, segment_pins)
		`CHK("board b", 4'hA, b_lvl)
		`CHK("synth en", 1'b1, synth_drive_high_pin_en)
		`CHK("synth all en", 3'h7, synth_en)
		pulse_req(3'h1);
		`CHK("in_halt", 1'b0, in_halt)
	endtask
	task give_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		{reset_n, chip_enable, halt_req, stop_req, wake_req} <= '0;
		{bidir_port_b_out, bidir_port_b_oe, bidir_port_d_out} <= '0;
		{bidir_port_d_oe, bidir_port_c_out, bidir_port_c_oe} <= '0;
		{analog_pd_sel, output_port_c_serial_out_val, synth_sw_enable} <= '0;
		{synth_drive_low_val, synth_drive_high_val, phase_error_val} <= '0;
		{output_port_a_val, output_port_b_val, seg_gpo_sel} <= '0;
		{seg_gpo_val, seg_drive_val} <= '0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		t_stop;
		t_nop;
		t_halt;
		give_verdict;
	end
	initial begin
		repeat (1000) @(posedge clk);
		failures++;
		give_verdict;
	end
endmodule // spsc_standby_pins_tb
